// [rtl/fll_top.v]
// flash latch load and row write call sequencer
// How it works
// - load length is one to 256 bytes
// - latch offset comes from word0 bits 23:16
// - latch keeps data until a program clears it
// - load call keys B6 D7, opcode 0004
// - word0 top byte selects flash array
// - length byte at offset 04, value plus one
// - data bytes fetched in order from offset 08
// - row write erases then programs the row
// - all-zero latch skips the programming phase
// - a completed row write clears the whole latch afterwards; a refused one leaves it
// - protected rows are refused and left untouched
// - row write keys B6 D8, row in 31:16, opcode 0005
// - completion clears elevated and call request flags
// - status A in top nibble or F00000YY
// - wrong oscillator pump clock aborts with status
`timescale 1ns/100ps
`include "fll_consts.vh"
module fll_top (
   // clock and reset
   input  wire        CLK_SYS,
   input  wire        RST_N,
   // call registers
   input  wire        ARG_WR,
   input  wire [31:0] ARG_WDATA,
   input  wire        REQ_WR,
   input  wire [31:0] REQ_WDATA,
   output reg  [31:0] ARG_RDATA_Q,
   output reg  [31:0] REQ_RDATA_Q,
   // sram read port
   output reg         SRAM_RD_Q,
   output reg  [31:0] SRAM_ADDR_Q,
   input  wire        SRAM_RVALID,
   input  wire [31:0] SRAM_RDATA,
   // oscillator status, asynchronous
   input  wire        PUMP_FROM_OSC,
   input  wire        OSC_AT_48MHZ,
   // flash macro
   output reg         FL_ERASE_GO_Q,
   output reg         FL_PROG_GO_Q,
   output reg  [15:0] FL_ROW_Q,
   output reg  [7:0]  FL_ARRAY_Q,
   input  wire        FL_DONE,
   input  wire        ROW_PROTECTED,
   input  wire [6:0]  FL_LATCH_ADDR,
   output wire [7:0]  FL_LATCH_DATA_Q
);
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_P0   = 3'd1;
   localparam [2:0] S_P1   = 3'd2;
   localparam [2:0] S_DW   = 3'd3;
   localparam [2:0] S_DB   = 3'd4;
   localparam [2:0] S_CK   = 3'd5;
   localparam [2:0] S_ER   = 3'd6;
   localparam [2:0] S_PG   = 3'd7;

   reg [2:0]  state_q, state_d;
   reg [31:0] arg_q, arg_d, req_q, req_d;
   reg        rd_q, rd_d, er_q, er_d, pg_q, pg_d;
   reg [31:0] addr_q, addr_d, wd_q, wd_d;
   reg [15:0] row_q, row_d;
   reg [7:0]  arr_q, arr_d, boff_q, boff_d, len_q, len_d, cnt_q, cnt_d;
   reg        lw_en, lclr;
   reg [1:0]  pump_s_q, osc_s_q;
   wire       latch_zero;
   wire       pump_bad;
   wire [7:0] cnt_nx;

   // oscillator bits come from another domain; first stage feeds only the second
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         pump_s_q <= 2'b00;
         osc_s_q  <= 2'b00;
      end else begin
         pump_s_q <= {pump_s_q[0], PUMP_FROM_OSC};
         osc_s_q  <= {osc_s_q[0], OSC_AT_48MHZ};
      end
   end

   assign pump_bad = pump_s_q[1] & ~osc_s_q[1];
   assign cnt_nx   = cnt_q + 8'h01;

   function [31:0] fail_code;
      input [7:0] why;
      fail_code = {`FLL_ST_FAIL, why};
   endfunction

   always @* begin
      state_d = state_q;
      arg_d   = arg_q;
      req_d   = req_q;
      rd_d    = 1'b0;
      er_d    = 1'b0;
      pg_d    = 1'b0;
      addr_d  = addr_q;
      wd_d    = wd_q;
      row_d   = row_q;
      arr_d   = arr_q;
      boff_d  = boff_q;
      len_d   = len_q;
      cnt_d   = cnt_q;
      lw_en   = 1'b0;
      lclr    = 1'b0;
      case (state_q)
         S_IDLE: begin
            // register writes are ignored while a call runs
            if (ARG_WR) begin
               arg_d = ARG_WDATA;
            end
            if (REQ_WR) begin
               req_d = REQ_WDATA;
               if (REQ_WDATA[`FLL_REQ_FLAG_BIT]) begin
                  req_d[`FLL_PRIV_FLAG_BIT] = 1'b1;
                  rd_d    = 1'b1;
                  addr_d  = ARG_WR ? ARG_WDATA : arg_q;
                  state_d = S_P0;
               end
            end
         end
         S_P0: begin
            if (SRAM_RVALID) begin
               if (req_q[15:0] != `FLL_OP_LOAD && req_q[15:0] != `FLL_OP_WRITE) begin
                  arg_d   = fail_code(`FLL_ERR_OPCODE);
                  state_d = S_IDLE;
               end else if (SRAM_RDATA[7:0] != `FLL_FIRST_KEY_BYTE ||
                            SRAM_RDATA[15:8] != ((req_q[15:0] == `FLL_OP_LOAD) ?
                            `FLL_SECOND_KEY_BYTE_LOAD : `FLL_SECOND_KEY_BYTE_WRITE)) begin
                  arg_d   = fail_code(`FLL_ERR_KEY);
                  state_d = S_IDLE;
               end else if (req_q[15:0] == `FLL_OP_LOAD) begin
                  boff_d  = SRAM_RDATA[23:16];
                  arr_d   = SRAM_RDATA[31:24];
                  rd_d    = 1'b1;
                  addr_d  = arg_q + `FLL_OFF_LEN;
                  state_d = S_P1;
               end else begin
                  row_d   = SRAM_RDATA[31:16];
                  state_d = S_CK;
               end
            end
         end
         S_P1: begin
            if (SRAM_RVALID) begin
               len_d   = SRAM_RDATA[7:0] + 8'h01;
               cnt_d   = 8'h00;
               rd_d    = 1'b1;
               addr_d  = arg_q + `FLL_OFF_DATA;
               state_d = S_DW;
            end
         end
         S_DW: begin
            if (SRAM_RVALID) begin
               wd_d    = SRAM_RDATA;
               state_d = S_DB;
            end
         end
         S_DB: begin
            lw_en = 1'b1;
            cnt_d = cnt_nx;
            if (cnt_nx == len_q) begin
               arg_d   = `FLL_ST_OK;
               state_d = S_IDLE;
            end else if (cnt_q[1:0] == 2'b11) begin
               rd_d    = 1'b1;
               addr_d  = arg_q + `FLL_OFF_DATA + {24'h00_0000, cnt_nx};
               state_d = S_DW;
            end
         end
         S_CK: begin
            // row number has been on the flash port a cycle; protection is valid now
            if (pump_bad) begin
               arg_d   = fail_code(`FLL_ERR_PUMP_CLK);
               state_d = S_IDLE;
            end else if (ROW_PROTECTED) begin
               arg_d   = fail_code(`FLL_ERR_PROTECT);
               state_d = S_IDLE;
            end else begin
               er_d    = 1'b1;
               state_d = S_ER;
            end
         end
         S_ER: begin
            if (FL_DONE) begin
               if (latch_zero) begin
                  lclr    = 1'b1;
                  arg_d   = `FLL_ST_OK;
                  state_d = S_IDLE;
               end else begin
                  pg_d    = 1'b1;
                  state_d = S_PG;
               end
            end
         end
         S_PG: begin
            if (FL_DONE) begin
               lclr    = 1'b1;
               arg_d   = `FLL_ST_OK;
               state_d = S_IDLE;
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
      if (state_q != S_IDLE && state_d == S_IDLE) begin
         req_d[`FLL_REQ_FLAG_BIT]  = 1'b0;
         req_d[`FLL_PRIV_FLAG_BIT] = 1'b0;
      end
   end

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= S_IDLE;
         arg_q   <= `FLL_ARG_RESET;
         req_q   <= `FLL_REQ_RESET;
         rd_q    <= 1'b0;
         er_q    <= 1'b0;
         pg_q    <= 1'b0;
         addr_q  <= 32'h0000_0000;
         wd_q    <= 32'h0000_0000;
         row_q   <= 16'h0000;
         arr_q   <= 8'h00;
         boff_q  <= 8'h00;
         len_q   <= 8'h00;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         arg_q   <= arg_d;
         req_q   <= req_d;
         rd_q    <= rd_d;
         er_q    <= er_d;
         pg_q    <= pg_d;
         addr_q  <= addr_d;
         wd_q    <= wd_d;
         row_q   <= row_d;
         arr_q   <= arr_d;
         boff_q  <= boff_d;
         len_q   <= len_d;
         cnt_q   <= cnt_d;
      end
   end

   always @* begin
      ARG_RDATA_Q   = arg_q;
      REQ_RDATA_Q   = req_q;
      SRAM_RD_Q     = rd_q;
      SRAM_ADDR_Q   = addr_q;
      FL_ERASE_GO_Q = er_q;
      FL_PROG_GO_Q  = pg_q;
      FL_ROW_Q      = row_q;
      FL_ARRAY_Q    = arr_q;
   end

   // offset plus count wraps inside the row; bytes past 127 go on from byte 0
   fll_latch u_latch (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .wr_en     (lw_en),
      .wr_addr   (boff_q[6:0] + cnt_q[6:0]),
      .wr_data   (wd_q[{cnt_q[1:0], 3'b000} +: 8]),
      .clr       (lclr),
      .rd_addr   (FL_LATCH_ADDR),
      .rd_data_q (FL_LATCH_DATA_Q),
      .all_zero  (latch_zero)
   );
endmodule // fll_top

// [rtl/fll_consts.vh]
// constants for the flash latch load and row write sequencer
`ifndef FLL_CONSTS_VH
`define FLL_CONSTS_VH
`define FLL_ROW_BYTES      128
`define FLL_OP_LOAD        16'h0004
`define FLL_OP_WRITE       16'h0005
`define FLL_FIRST_KEY_BYTE           8'hB6
`define FLL_SECOND_KEY_BYTE_LOAD      8'hD7
`define FLL_SECOND_KEY_BYTE_WRITE     8'hD8
`define FLL_REQ_FLAG_BIT   31
`define FLL_PRIV_FLAG_BIT  28
`define FLL_OFF_LEN        32'h0000_0004
`define FLL_OFF_DATA       32'h0000_0008
`define FLL_ARG_RESET      32'h0000_0000
`define FLL_REQ_RESET      32'h0000_0000
`define FLL_ST_OK          32'hA000_0000
`define FLL_ST_FAIL        24'hF0_0000
`define FLL_ERR_KEY        8'h03
`define FLL_ERR_OPCODE     8'h04
`define FLL_ERR_PROTECT    8'h05
`define FLL_ERR_PUMP_CLK   8'h06
`endif

// [rtl/fll_latch.v]
// page latch buffer: byte write, bulk clear, registered read, zero detect
`timescale 1ns/100ps
`include "fll_consts.vh"
module fll_latch (
   // clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // write and clear
   input  wire       wr_en,
   input  wire [6:0] wr_addr,
   input  wire [7:0] wr_data,
   input  wire       clr,
   // read
   input  wire [6:0] rd_addr,
   output reg  [7:0] rd_data_q,
   output reg        all_zero
);
   reg [7:0] mem_q [0:`FLL_ROW_BYTES-1];
   integer   i;
   integer   j;

   // contents stay put between calls; only a clear or a write touches them
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `FLL_ROW_BYTES; i = i + 1) begin
            mem_q[i] <= 8'h00;
         end
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= mem_q[rd_addr];
         if (clr) begin
            for (i = 0; i < `FLL_ROW_BYTES; i = i + 1) begin
               mem_q[i] <= 8'h00;
            end
         end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
         end
      end
   end

   always @* begin
      all_zero = 1'b1;
      // own loop index: the clocked process must stay the only driver of i
      for (j = 0; j < `FLL_ROW_BYTES; j = j + 1) begin
         if (mem_q[j] != 8'h00) begin
            all_zero = 1'b0;
         end
      end
   end
endmodule // fll_latch

// [tb/fll_assertions.sv]
// concurrent checks on the call sequencer ports
`timescale 1ns/100ps
module fll_chk (
   // clock and reset
   input wire        CLK_SYS,
   input wire        RST_N,
   // watched ports
   input wire        REQ_WR,
   input wire [31:0] REQ_WDATA,
   input wire [31:0] ARG_RDATA_Q,
   input wire [31:0] REQ_RDATA_Q,
   input wire        SRAM_RD_Q,
   input wire        FL_ERASE_GO_Q,
   input wire        FL_PROG_GO_Q,
   input wire        ROW_PROTECTED,
   input wire        PUMP_FROM_OSC,
   input wire        OSC_AT_48MHZ
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   chk_call_start: assert property (
      REQ_WR && REQ_WDATA[31] && !REQ_RDATA_Q[31] |=> REQ_RDATA_Q[31] && REQ_RDATA_Q[28])
      else $error("call flags not raised");
   chk_done_flags: assert property ($fell(REQ_RDATA_Q[31]) |-> !REQ_RDATA_Q[28])
      else $error("elevated flag left set");
   chk_status_code: assert property ($fell(REQ_RDATA_Q[31]) |->
      ARG_RDATA_Q[31:28] == 4'hA || ARG_RDATA_Q[31:8] == 24'hF0_0000)
      else $error("bad status form");
   chk_erase_in_write: assert property (
      FL_ERASE_GO_Q |-> REQ_RDATA_Q[31] && REQ_RDATA_Q[15:0] == 16'h0005)
      else $error("erase outside row write");
   chk_prog_in_write: assert property (
      FL_PROG_GO_Q |-> REQ_RDATA_Q[31] && REQ_RDATA_Q[15:0] == 16'h0005)
      else $error("program outside row write");
   chk_erase_pulse: assert property (FL_ERASE_GO_Q |=> !FL_ERASE_GO_Q && !FL_PROG_GO_Q)
      else $error("erase pulse too long");
   chk_protect_kept: assert property (FL_ERASE_GO_Q |-> !$past(ROW_PROTECTED, 1))
      else $error("protected row erased");
   chk_pump_clock: assert property (
      FL_ERASE_GO_Q |-> !($past(PUMP_FROM_OSC, 3) && !$past(OSC_AT_48MHZ, 3)))
      else $error("erase with bad pump clock");
   chk_sram_in_call: assert property (SRAM_RD_Q |-> REQ_RDATA_Q[31])
      else $error("sram read while idle");
endmodule // fll_chk
bind fll_top fll_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ_WR(REQ_WR),
   .REQ_WDATA(REQ_WDATA), .ARG_RDATA_Q(ARG_RDATA_Q), .REQ_RDATA_Q(REQ_RDATA_Q),
   .SRAM_RD_Q(SRAM_RD_Q), .FL_ERASE_GO_Q(FL_ERASE_GO_Q), .FL_PROG_GO_Q(FL_PROG_GO_Q),
   .ROW_PROTECTED(ROW_PROTECTED), .PUMP_FROM_OSC(PUMP_FROM_OSC), .OSC_AT_48MHZ(OSC_AT_48MHZ));

// [tb/fll_far.sv]
// sram holding the parameter block, and a flash macro with slow erase
`timescale 1ns/100ps
module fll_far (
   // clock
   input  wire        clk,
   // sram read port
   input  wire        rd,
   input  wire [31:0] addr,
   output reg         rvalid,
   output reg  [31:0] rdata,
   // flash macro
   input  wire        erase_go,
   input  wire        prog_go,
   output reg         done
);
   reg [31:0] mem [0:127];
   integer    n_erase = 0;
   integer    n_prog = 0;
   integer    cnt = 0;
   initial begin
      rvalid = 0;
      rdata = 0;
      done = 0;
   end
   always @(posedge clk) begin
      rvalid <= rd;
      // idle bus flips so a stale word is never read as fresh
      rdata <= rd ? mem[addr[8:2]] : ~rdata;
      done <= (cnt == 1);
      if (cnt != 0) cnt <= cnt - 1;
      if (erase_go) begin
         n_erase <= n_erase + 1;
         cnt <= 9;
      end
      if (prog_go) begin
         n_prog <= n_prog + 1;
         cnt <= 3;
      end
   end
endmodule // fll_far

// [tb/tb_top.sv]
// self-checking bench for the call sequencer
`timescale 1ns/100ps
`include "fll_consts.vh"
module tb_top;
   reg         CLK_SYS = 0, RST_N = 0, ARG_WR = 0, REQ_WR = 0;
   reg  [31:0] ARG_WDATA = 0, REQ_WDATA = 0;
   reg         PUMP_FROM_OSC = 1, OSC_AT_48MHZ = 1, ROW_PROTECTED = 0;
   reg  [6:0]  FL_LATCH_ADDR = 0;
   wire [31:0] ARG_RDATA_Q, REQ_RDATA_Q, SRAM_ADDR_Q, SRAM_RDATA;
   wire [15:0] FL_ROW_Q;
   wire [7:0]  FL_ARRAY_Q, FL_LATCH_DATA_Q;
   wire        SRAM_RD_Q, SRAM_RVALID, FL_ERASE_GO_Q, FL_PROG_GO_Q, FL_DONE;
   integer     err_count = 0, n_compared = 0, k;
   always #2 CLK_SYS = ~CLK_SYS;
   fll_top u_fll_top (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ARG_WR(ARG_WR),
      .ARG_WDATA(ARG_WDATA), .REQ_WR(REQ_WR), .REQ_WDATA(REQ_WDATA),
      .ARG_RDATA_Q(ARG_RDATA_Q), .REQ_RDATA_Q(REQ_RDATA_Q), .SRAM_RD_Q(SRAM_RD_Q),
      .SRAM_ADDR_Q(SRAM_ADDR_Q), .SRAM_RVALID(SRAM_RVALID), .SRAM_RDATA(SRAM_RDATA),
      .PUMP_FROM_OSC(PUMP_FROM_OSC), .OSC_AT_48MHZ(OSC_AT_48MHZ),
      .FL_ERASE_GO_Q(FL_ERASE_GO_Q), .FL_PROG_GO_Q(FL_PROG_GO_Q), .FL_ROW_Q(FL_ROW_Q),
      .FL_ARRAY_Q(FL_ARRAY_Q), .FL_DONE(FL_DONE), .ROW_PROTECTED(ROW_PROTECTED),
      .FL_LATCH_ADDR(FL_LATCH_ADDR), .FL_LATCH_DATA_Q(FL_LATCH_DATA_Q));
   fll_far u_fll_far (.clk(CLK_SYS), .rd(SRAM_RD_Q), .addr(SRAM_ADDR_Q),
      .rvalid(SRAM_RVALID), .rdata(SRAM_RDATA), .erase_go(FL_ERASE_GO_Q),
      .prog_go(FL_PROG_GO_Q), .done(FL_DONE));
   task test_done;
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one call: argument and request written in the same cycle, then poll
   task call(input [31:0] a, input [15:0] op, input [31:0] st);
      integer i;
      @(posedge CLK_SYS);
      ARG_WR <= 1;
      ARG_WDATA <= a;
      REQ_WR <= 1;
      REQ_WDATA <= {16'h8000, op};
      @(posedge CLK_SYS);
      ARG_WR <= 0;
      REQ_WR <= 0;
      i = 0;
      do begin
         @(posedge CLK_SYS);
         #1 i++;
      end while (REQ_RDATA_Q[31] !== 1'b0 && i < 1000);
      if (i >= 1000) begin
         err_count++;
         test_done;
      end
      chk("elevated flag", 0, REQ_RDATA_Q[28]);
      chk("status", st, ARG_RDATA_Q);
   endtask
   task lat(input [6:0] a, input [7:0] e);
      @(posedge CLK_SYS);
      FL_LATCH_ADDR <= a;
      @(posedge CLK_SYS);
      @(posedge CLK_SYS);
      #1 chk("latch byte", e, FL_LATCH_DATA_Q);
   endtask
   task t_full_load;
      u_fll_far.mem[32] = 32'h0000_D7B6;
      u_fll_far.mem[33] = 32'h0000_007F;
      for (k = 0; k < 32; k++)
         u_fll_far.mem[34+k] = {8'(4*k+4), 8'(4*k+3), 8'(4*k+2), 8'(4*k+1)};
      call(32'h0000_0080, `FLL_OP_LOAD, `FLL_ST_OK);
      lat(7'h00, 8'h01);
      lat(7'h7F, 8'h80);
   endtask
   task t_part_load;
      u_fll_far.mem[4] = 32'h017E_D7B6;
      u_fll_far.mem[5] = 32'hFFFF_FF03;
      u_fll_far.mem[6] = 32'h4433_2211;
      call(32'h0000_0010, `FLL_OP_LOAD, `FLL_ST_OK);
      lat(7'h7F, 8'h22);
      lat(7'h01, 8'h44);
      lat(7'h02, 8'h03);
      chk("array select", 8'h01, FL_ARRAY_Q);
   endtask
   task t_bad_key;
      u_fll_far.mem[8] = 32'h0000_D8B6;
      call(32'h0000_0020, `FLL_OP_LOAD, {`FLL_ST_FAIL, `FLL_ERR_KEY});
      call(32'h0000_0020, 16'h0006, {`FLL_ST_FAIL, `FLL_ERR_OPCODE});
      lat(7'h7F, 8'h22);
   endtask
   task t_protect;
      u_fll_far.mem[12] = 32'h0009_D8B6;
      @(posedge CLK_SYS);
      ROW_PROTECTED <= 1;
      call(32'h0000_0030, `FLL_OP_WRITE, {`FLL_ST_FAIL, `FLL_ERR_PROTECT});
      chk("erase count", 0, u_fll_far.n_erase);
      @(posedge CLK_SYS);
      ROW_PROTECTED <= 0;
   endtask
   task t_pump;
      @(posedge CLK_SYS);
      OSC_AT_48MHZ <= 0;
      repeat (4) @(posedge CLK_SYS);
      call(32'h0000_0030, `FLL_OP_WRITE, {`FLL_ST_FAIL, `FLL_ERR_PUMP_CLK});
      chk("erase count", 0, u_fll_far.n_erase);
      @(posedge CLK_SYS);
      OSC_AT_48MHZ <= 1;
      repeat (4) @(posedge CLK_SYS);
   endtask
   task t_write;
      call(32'h0000_0030, `FLL_OP_WRITE, `FLL_ST_OK);
      chk("erase count", 1, u_fll_far.n_erase);
      chk("program count", 1, u_fll_far.n_prog);
      chk("row number", 16'h0009, FL_ROW_Q);
      lat(7'h7F, 8'h00);
      lat(7'h02, 8'h00);
   endtask
   task t_zero_write;
      call(32'h0000_0030, `FLL_OP_WRITE, `FLL_ST_OK);
      chk("erase count", 2, u_fll_far.n_erase);
      chk("program count", 1, u_fll_far.n_prog);
   endtask
   initial begin
      repeat (12) @(posedge CLK_SYS);
      RST_N <= 1;
      t_full_load;
      t_part_load;
      t_bad_key;
      t_protect;
      t_pump;
      t_write;
      t_zero_write;
      test_done;
   end
endmodule // tb_top
